//--- design/ilc_regs.svh
`ifndef ILC_REGS_SVH
`define ILC_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
// ==========================================================================
`define ILC_OFF_OWN_CTRL_WR     8'h00
`define ILC_OFF_OWN_PERI_WR     8'h04
`define ILC_OFF_OWN_STATE       8'h08
`define ILC_OFF_DRIVE_ON_WR     8'h10
`define ILC_OFF_DRIVE_OFF_WR    8'h14
`define ILC_OFF_DRIVE_STATE     8'h18
`define ILC_OFF_LEVEL_SET_WR    8'h30
`define ILC_OFF_LEVEL_CLR_WR    8'h34
`define ILC_OFF_DRIVEN_LEVEL    8'h38
`define ILC_OFF_PIN_LEVEL       8'h3c
`define ILC_OFF_OD_ON_WR        8'h50
`define ILC_OFF_OD_OFF_WR       8'h54
`define ILC_OFF_OD_STATE        8'h58
`define ILC_OFF_PU_OFF_WR       8'h60
`define ILC_OFF_PU_ON_WR        8'h64
`define ILC_OFF_PU_STATE        8'h68
`define ILC_OFF_FSEL_LOW        8'h70
`define ILC_OFF_FSEL_HIGH       8'h74
`define ILC_OFF_PD_OFF_WR       8'h90
`define ILC_OFF_PD_ON_WR        8'h94
`define ILC_OFF_PD_STATE        8'h98
`define ILC_OFF_MASK_ON_WR      8'ha0
`define ILC_OFF_MASK_OFF_WR     8'ha4
`define ILC_OFF_MASK_STATE      8'ha8

// ==========================================================================
// Reset values
// ==========================================================================
`define ILC_RST_DRIVE_STATE     32'h0000_0000
`define ILC_RST_DRIVEN_LEVEL    32'h0000_0000
`define ILC_RST_OD_STATE        32'h0000_0000
`define ILC_RST_MASK_STATE      32'h0000_0000
`define ILC_RST_FSEL            32'h0000_0000
`define ILC_RST_PIN_LEVEL       32'h0000_0000
`define ILC_RST_OWN_STATE       32'hffff_ffff
`define ILC_RST_PU_STATE        32'h0000_0000
`define ILC_RST_PD_STATE        32'hffff_ffff

// ==========================================================================
// Widths
// ==========================================================================
`define ILC_ADDR_W              8
`define ILC_DATA_W              32
`define ILC_NUM_FUNCS           4

`endif

//--- design/ilc_pkg.sv
`include "ilc_regs.svh"

package ilc_pkg;

  // ========================================================================
  // Types
  // ========================================================================
  // One register bus request, as driven by the master in one cycle.
  typedef struct packed {
    logic [`ILC_ADDR_W-1:0] addr;
    logic [`ILC_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } ilc_bus_req_t;

  // Peripheral function encoding: {high select bit, low select bit}.
  typedef enum logic [1:0] {
    ILC_FUNC_A = 2'h0,
    ILC_FUNC_B = 2'h1,
    ILC_FUNC_C = 2'h2,
    ILC_FUNC_D = 2'h3
  } ilc_func_t;

endpackage : ilc_pkg

//--- design/ilc_setclr_reg.sv
`timescale 1ns/100ps

// Generic set/clear status register: ones in setMask set, ones in clrMask clear.
module ilc_setclr_reg #(
  parameter int              W         = 32,
  parameter logic [W-1:0]    RESET_VAL = '0
) (
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  input  wire logic [W-1:0]  setMask,
  input  wire logic [W-1:0]  clrMask,
  output logic      [W-1:0]  state
);

  logic [W-1:0] stateReg;
  logic [W-1:0] stateNext;

  // Zero bits in both masks leave the state alone; set takes priority.
  always_comb begin
    stateNext = (stateReg & ~clrMask) | setMask;
  end

  // The register runs from the bus clock, not the gated peripheral clock.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg <= RESET_VAL;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign state = stateReg;

endmodule : ilc_setclr_reg

//--- design/ilc_line_mux.sv
`timescale 1ns/100ps

// Output steering for one I/O line: controller or one of four peripherals.
module ilc_line_mux
  import ilc_pkg::*;
(
  input  wire logic                      ctrlOwned,
  input  wire ilc_pkg::ilc_func_t        funcSel,
  input  wire logic [`ILC_NUM_FUNCS-1:0] funcPresent,
  input  wire logic [`ILC_NUM_FUNCS-1:0] perOut,
  input  wire logic [`ILC_NUM_FUNCS-1:0] perOe,
  input  wire logic                      ctrlOe,
  input  wire logic                      ctrlLevel,
  input  wire logic                      openDrain,
  output logic                           padOut,
  output logic                           padOe
);

  logic selOut;
  logic selOe;
  logic rawOut;
  logic rawOe;

  // Only the output and enable paths are steered; inputs bypass this mux.
  always_comb begin
    selOut = perOut[funcSel];
    selOe  = perOe[funcSel] & funcPresent[funcSel];
  end

  // Owner decides both whether the pad is driven and with what value.
  always_comb begin
    if (ctrlOwned) begin
      rawOut = ctrlLevel;
      rawOe  = ctrlOe;
    end else begin
      rawOut = selOut;
      rawOe  = selOe;
    end
  end

  // Open drain never drives high, whatever the owner; a one releases the pad.
  always_comb begin
    padOut = openDrain ? 1'b0 : rawOut;
    padOe  = rawOe & ~(openDrain & rawOut);
  end

endmodule : ilc_line_mux

//--- design/ilc_io_line_controller.sv
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps

// ==========================================================================
// I/O line controller: ownership, peripheral mux, output and resistor control
// ==========================================================================
// Summary of operation
// - Configuration writes are stored whether or not the peripheral clock runs.
// - Live pin level sampling only advances while the peripheral clock is enabled.
// - No interrupt may be asserted while the peripheral clock is disabled.
// - Pull-up on/off writes clear/set pull-up state; one means resistor off.
// - Pull-down on/off writes clear/set pull-down state; one means resistor off.
// - Pull-down enable is discarded on lines whose pull-up is on.
// - Pull-up enable is discarded on lines whose pull-down is on.
// - Pull-up control ignores line ownership and drive direction.
// - Ownership writes set/clear ownership state; one is controller, zero peripheral.
// - Lines without a peripheral ignore ownership writes and read ownership one.
// - Ownership reset value is a per-product parameter, normally all ones.
// - Low/high select bits pick function A, B, C or D per line.
// - Peripheral inputs always see the pad input regardless of selection.
// - Both select registers reset to zero and are writable in any ownership.
// - Selecting a missing function is stored unchecked; pad enable stays off.
// - Peripheral-owned lines are driven and valued by the selected peripheral.
// - Drive on/off writes set/clear drive state; one means controller drives.
// - Level and drive writes update state even while peripheral-owned.
// - Direct driven-level writes change only bits enabled in the write mask.
// - Direct-write mask resets to zero, so direct writes change nothing until mask bits are set.
// - Open-drain state set/clear in any ownership; set means drive low only.
// - Open-drain state resets to zero: push-pull on every line.
// - Register bit i corresponds to I/O line i.
module ilc_io_line_controller
  import ilc_pkg::*;
#(
  parameter int                                 NUM_LINES   = 32,
  parameter logic [NUM_LINES-1:0]               MUX_PRESENT = '1,
  parameter logic [NUM_LINES-1:0]               OWN_RESET   = `ILC_RST_OWN_STATE,
  parameter logic [NUM_LINES-1:0]               PU_RESET    = `ILC_RST_PU_STATE,
  parameter logic [NUM_LINES-1:0]               PD_RESET    = `ILC_RST_PD_STATE,
  parameter logic [NUM_LINES*`ILC_NUM_FUNCS-1:0] FUNC_PRESENT = '1
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  input  wire ilc_pkg::ilc_bus_req_t                busReq,
  output logic [`ILC_DATA_W-1:0]                    busRdata,
  input  wire logic                                 periphClkEn,
  input  wire logic [NUM_LINES-1:0]                 padIn,
  output logic [NUM_LINES-1:0]                      padOut,
  output logic [NUM_LINES-1:0]                      padOe,
  output logic [NUM_LINES-1:0]                      pullUpEn,
  output logic [NUM_LINES-1:0]                      pullDownEn,
  input  wire logic [NUM_LINES*`ILC_NUM_FUNCS-1:0]  perOut,
  input  wire logic [NUM_LINES*`ILC_NUM_FUNCS-1:0]  perOe,
  output logic [NUM_LINES-1:0]                      perIn
);

  // ========================================================================
  // Bus decode helpers
  // ========================================================================
  // True when the current request is a write to the given offset.
  function automatic logic wrHit(input ilc_bus_req_t req,
                                 input logic [`ILC_ADDR_W-1:0] off);
    wrHit = req.wr && (req.addr == off);
  endfunction : wrHit

  // Widen line-sized state to the bus word; upper bits read as zero.
  function automatic logic [`ILC_DATA_W-1:0] toWord(input logic [NUM_LINES-1:0] v);
    logic [`ILC_DATA_W-1:0] w;
    w = '0;
    w[NUM_LINES-1:0] = v;
    toWord = w;
  endfunction : toWord

  logic [NUM_LINES-1:0] wdataLines;
  logic [NUM_LINES-1:0] noLines;

  // Bit i of the write data addresses line i throughout.
  assign wdataLines = busReq.wdata[NUM_LINES-1:0];
  assign noLines    = '0;

  // ========================================================================
  // Per-register write masks
  // ========================================================================
  logic [NUM_LINES-1:0] ownSet;
  logic [NUM_LINES-1:0] ownClr;
  logic [NUM_LINES-1:0] driveSet;
  logic [NUM_LINES-1:0] driveClr;
  logic [NUM_LINES-1:0] odSet;
  logic [NUM_LINES-1:0] odClr;
  logic [NUM_LINES-1:0] maskSet;
  logic [NUM_LINES-1:0] maskClr;
  logic [NUM_LINES-1:0] levelSet;
  logic [NUM_LINES-1:0] levelClr;
  logic [NUM_LINES-1:0] puSet;
  logic [NUM_LINES-1:0] puClr;
  logic [NUM_LINES-1:0] pdSet;
  logic [NUM_LINES-1:0] pdClr;

  logic [NUM_LINES-1:0] ownState;
  logic [NUM_LINES-1:0] ownStateRaw;
  logic [NUM_LINES-1:0] driveState;
  logic [NUM_LINES-1:0] odState;
  logic [NUM_LINES-1:0] maskState;
  logic [NUM_LINES-1:0] levelState;
  logic [NUM_LINES-1:0] puState;
  logic [NUM_LINES-1:0] pdState;

  // Lines without a peripheral never see ownership writes.
  always_comb begin
    ownSet = wrHit(busReq, `ILC_OFF_OWN_CTRL_WR) ? (wdataLines & MUX_PRESENT) : noLines;
    ownClr = wrHit(busReq, `ILC_OFF_OWN_PERI_WR) ? (wdataLines & MUX_PRESENT) : noLines;
  end

  // Drive and open-drain writes do not look at ownership, so they preset lines.
  always_comb begin
    driveSet = wrHit(busReq, `ILC_OFF_DRIVE_ON_WR) ? wdataLines : noLines;
    driveClr = wrHit(busReq, `ILC_OFF_DRIVE_OFF_WR) ? wdataLines : noLines;
    odSet    = wrHit(busReq, `ILC_OFF_OD_ON_WR) ? wdataLines : noLines;
    odClr    = wrHit(busReq, `ILC_OFF_OD_OFF_WR) ? wdataLines : noLines;
    maskSet  = wrHit(busReq, `ILC_OFF_MASK_ON_WR) ? wdataLines : noLines;
    maskClr  = wrHit(busReq, `ILC_OFF_MASK_OFF_WR) ? wdataLines : noLines;
  end

  // A direct write becomes a masked set plus a masked clear in one cycle, so
  // lines can rise and fall together without a glitch between two writes.
  always_comb begin
    levelSet = noLines;
    levelClr = noLines;
    if (wrHit(busReq, `ILC_OFF_LEVEL_SET_WR)) begin
      levelSet = wdataLines;
    end
    if (wrHit(busReq, `ILC_OFF_LEVEL_CLR_WR)) begin
      levelClr = wdataLines;
    end
    if (wrHit(busReq, `ILC_OFF_DRIVEN_LEVEL)) begin
      levelSet = wdataLines & maskState;
      levelClr = ~wdataLines & maskState;
    end
  end

  // Resistor state bits are one for off. An enable clears the bit, but only
  // where the opposite resistor is off, so both can never be on together.
  always_comb begin
    puSet = wrHit(busReq, `ILC_OFF_PU_OFF_WR) ? wdataLines : noLines;
    puClr = wrHit(busReq, `ILC_OFF_PU_ON_WR) ? (wdataLines & pdState) : noLines;
    pdSet = wrHit(busReq, `ILC_OFF_PD_OFF_WR) ? wdataLines : noLines;
    pdClr = wrHit(busReq, `ILC_OFF_PD_ON_WR) ? (wdataLines & puState) : noLines;
  end

  // ========================================================================
  // Set/clear state registers
  // ========================================================================
  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (OWN_RESET | ~MUX_PRESENT)
  ) u_own (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (ownSet),
    .clrMask (ownClr),
    .state   (ownStateRaw)
  );

  // Belt and braces: unmuxed lines read as controller-owned in any case.
  assign ownState = ownStateRaw | ~MUX_PRESENT;

  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (NUM_LINES'(`ILC_RST_DRIVE_STATE))
  ) u_drive (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (driveSet),
    .clrMask (driveClr),
    .state   (driveState)
  );

  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (NUM_LINES'(`ILC_RST_OD_STATE))
  ) u_od (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (odSet),
    .clrMask (odClr),
    .state   (odState)
  );

  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (NUM_LINES'(`ILC_RST_MASK_STATE))
  ) u_mask (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (maskSet),
    .clrMask (maskClr),
    .state   (maskState)
  );

  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (NUM_LINES'(`ILC_RST_DRIVEN_LEVEL))
  ) u_level (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (levelSet),
    .clrMask (levelClr),
    .state   (levelState)
  );

  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (PU_RESET)
  ) u_pu (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (puSet),
    .clrMask (puClr),
    .state   (puState)
  );

  ilc_setclr_reg #(
    .W         (NUM_LINES),
    .RESET_VAL (PD_RESET)
  ) u_pd (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .setMask (pdSet),
    .clrMask (pdClr),
    .state   (pdState)
  );

  // Resistor enables ignore owner and direction entirely.
  assign pullUpEn   = ~puState;
  assign pullDownEn = ~pdState;

  // ========================================================================
  // Function select registers
  // ========================================================================
  logic [NUM_LINES-1:0] fselLowReg;
  logic [NUM_LINES-1:0] fselHighReg;

  // Plain word writes, stored without any check against the product mux.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fselLowReg <= NUM_LINES'(`ILC_RST_FSEL);
    end else if (wrHit(busReq, `ILC_OFF_FSEL_LOW)) begin
      fselLowReg <= wdataLines;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fselHighReg <= NUM_LINES'(`ILC_RST_FSEL);
    end else if (wrHit(busReq, `ILC_OFF_FSEL_HIGH)) begin
      fselHighReg <= wdataLines;
    end
  end

  // ========================================================================
  // Pin level sampling
  // ========================================================================
  logic [NUM_LINES-1:0] pinLevelReg;

  // With the peripheral clock gated the sample freezes at its last value;
  // there is no event or interrupt path, so nothing can fire while gated.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinLevelReg <= NUM_LINES'(`ILC_RST_PIN_LEVEL);
    end else if (periphClkEn) begin
      pinLevelReg <= padIn;
    end
  end

  // ========================================================================
  // Per-line output steering
  // ========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      ilc_line_mux u_mux (
        .ctrlOwned   (ownState[gi]),
        .funcSel     (ilc_func_t'({fselHighReg[gi], fselLowReg[gi]})),
        .funcPresent (FUNC_PRESENT[gi*`ILC_NUM_FUNCS +: `ILC_NUM_FUNCS]),
        .perOut      (perOut[gi*`ILC_NUM_FUNCS +: `ILC_NUM_FUNCS]),
        .perOe       (perOe[gi*`ILC_NUM_FUNCS +: `ILC_NUM_FUNCS]),
        .ctrlOe      (driveState[gi]),
        .ctrlLevel   (levelState[gi]),
        .openDrain   (odState[gi]),
        .padOut      (padOut[gi]),
        .padOe       (padOe[gi])
      );
    end
  endgenerate

  // Every peripheral sees the raw pad, unfiltered and unmuxed.
  assign perIn = padIn;

  // ========================================================================
  // Read data
  // ========================================================================
  logic [`ILC_DATA_W-1:0] rdataReg;
  logic [`ILC_DATA_W-1:0] rdataNext;

  // Write-only and unmapped offsets read as zero; state is read-only except the driven level and the two select registers, which direct writes change.
  always_comb begin
    rdataNext = '0;
    if (busReq.rd) begin
      unique case (busReq.addr)
        `ILC_OFF_OWN_STATE:    rdataNext = toWord(ownState);
        `ILC_OFF_DRIVE_STATE:  rdataNext = toWord(driveState);
        `ILC_OFF_DRIVEN_LEVEL: rdataNext = toWord(levelState);
        `ILC_OFF_PIN_LEVEL:    rdataNext = toWord(pinLevelReg);
        `ILC_OFF_OD_STATE:     rdataNext = toWord(odState);
        `ILC_OFF_PU_STATE:     rdataNext = toWord(puState);
        `ILC_OFF_PD_STATE:     rdataNext = toWord(pdState);
        `ILC_OFF_FSEL_LOW:     rdataNext = toWord(fselLowReg);
        `ILC_OFF_FSEL_HIGH:    rdataNext = toWord(fselHighReg);
        `ILC_OFF_MASK_STATE:   rdataNext = toWord(maskState);
        default:               rdataNext = '0;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe and are zero otherwise.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdataReg <= '0;
    end else begin
      rdataReg <= rdataNext;
    end
  end

  assign busRdata = rdataReg;

endmodule : ilc_io_line_controller

//--- verif/ilc_pad_model.sv
`timescale 1ns/100ps

// ==========================================================================
// Pads and peripheral functions on the far side of the controller
// ==========================================================================
module ilc_pad_model #(
  parameter int N = 32
) (
  input  wire logic         sys_clk,
  input  wire logic [N-1:0] padOut,
  input  wire logic [N-1:0] padOe,
  input  wire logic [N-1:0] pullUpEn,
  input  wire logic [N-1:0] pullDownEn,
  output logic      [N-1:0] padIn,
  output logic    [N*4-1:0] perOut,
  output logic    [N*4-1:0] perOe
);
  logic [N-1:0] floatLvl = '0;

  // A floating pad flips every cycle so a stale value never passes for a level.
  always @(posedge sys_clk) begin
    floatLvl <= ~floatLvl;
  end

  // Driven pads show the driver, released ones follow whichever resistor is on.
  always_comb begin
    padIn = (padOe & padOut) | (~padOe & (pullUpEn | (~pullDownEn & floatLvl)));
  end

  // Line i drives and enables only function i mod 4, so a wrong select reads zero.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      for (int f = 0; f < 4; f++) begin
        perOut[4*i+f] = (f == i % 4);
        perOe[4*i+f]  = (f == i % 4);
      end
    end
  end
endmodule : ilc_pad_model

//--- verif/ilc_io_line_controller_chk.sv
`timescale 1ns/100ps
`include "ilc_regs.svh"

// ==========================================================================
// Port-level checks of the I/O line controller
// ==========================================================================
module ilc_io_line_controller_chk #(
  parameter int NUM_LINES = 32
) (
  input wire logic                                sys_clk,
  input wire logic                                nrst,
  input wire ilc_pkg::ilc_bus_req_t               busReq,
  input wire logic [`ILC_DATA_W-1:0]              busRdata,
  input wire logic                                periphClkEn,
  input wire logic [NUM_LINES-1:0]                padIn,
  input wire logic [NUM_LINES-1:0]                padOut,
  input wire logic [NUM_LINES-1:0]                padOe,
  input wire logic [NUM_LINES-1:0]                pullUpEn,
  input wire logic [NUM_LINES-1:0]                pullDownEn,
  input wire logic [NUM_LINES*`ILC_NUM_FUNCS-1:0] perOut,
  input wire logic [NUM_LINES*`ILC_NUM_FUNCS-1:0] perOe,
  input wire logic [NUM_LINES-1:0]                perIn
);
  import ilc_pkg::*;
  logic [NUM_LINES-1:0] wd;

  // Write data narrowed to the line count.
  assign wd = busReq.wdata[NUM_LINES-1:0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  periph_input_a: assert property (perIn == padIn)
    else $error("peripheral input not pad");
  pull_exclusive_a: assert property ((pullUpEn & pullDownEn) == '0)
    else $error("both resistors on");
  pullup_off_a: assert property (busReq.wr && busReq.addr == `ILC_OFF_PU_OFF_WR |=>
    (pullUpEn & $past(wd)) == '0) else $error("pull-up off write ignored");
  pulldown_off_a: assert property (busReq.wr && busReq.addr == `ILC_OFF_PD_OFF_WR |=>
    (pullDownEn & $past(wd)) == '0) else $error("pull-down off write ignored");
  pulldown_on_a: assert property (busReq.wr && busReq.addr == `ILC_OFF_PD_ON_WR |=>
    pullDownEn == ($past(pullDownEn) | ($past(wd) & ~$past(pullUpEn))))
    else $error("pull-down on write misapplied");
  pullup_on_a: assert property (busReq.wr && busReq.addr == `ILC_OFF_PU_ON_WR |=>
    pullUpEn == ($past(pullUpEn) | ($past(wd) & ~$past(pullDownEn))))
    else $error("pull-up on write misapplied");
  pull_hold_a: assert property (!busReq.wr |=> $stable(pullUpEn) && $stable(pullDownEn))
    else $error("resistor changed unbidden");
  drive_hold_a: assert property (!busReq.wr ##1 $stable(perOe) |-> $stable(padOe))
    else $error("pad enable changed unbidden");
  rdata_idle_a: assert property (!$past(busReq.rd) |-> busRdata == '0)
    else $error("read data outside read slot");
  pullup_read_a: assert property (busReq.rd && busReq.addr == `ILC_OFF_PU_STATE |=>
    busRdata[NUM_LINES-1:0] == ~$past(pullUpEn)) else $error("pull-up state read wrong");

  cover_pd_refused: cover property (busReq.wr && busReq.addr == `ILC_OFF_PD_ON_WR
    && (wd & pullUpEn) != '0);
  cover_pin_read: cover property (busReq.rd && busReq.addr == `ILC_OFF_PIN_LEVEL);
  cover_clk_off: cover property (!periphClkEn && busReq.wr);
endmodule : ilc_io_line_controller_chk

//--- verif/tb.sv
`timescale 1ns/100ps
`include "ilc_regs.svh"

module tb;
  import ilc_pkg::*;
  localparam int          N   = 32;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic                   sys_clk;
  logic                   nrst;
  ilc_bus_req_t           busReq;
  logic [31:0]            busRdata;
  logic                   periphClkEn;
  logic [N-1:0]           padIn;
  logic [N-1:0]           padOut;
  logic [N-1:0]           padOe;
  logic [N-1:0]           pullUpEn;
  logic [N-1:0]           pullDownEn;
  logic [N-1:0]           perIn;
  logic [N*4-1:0]         perOut;
  logic [N*4-1:0]         perOe;
  int                     failures;
  int                     n_checks;

  // Line 9 has no peripheral and function D of line 7 is missing.
  ilc_io_line_controller #(
    .NUM_LINES(N), .MUX_PRESENT(32'hffff_fdff), .FUNC_PRESENT(~128'h8000_0000)
  ) u_ilc_io_line_controller (
    .sys_clk(sys_clk), .nrst(nrst), .busReq(busReq), .busRdata(busRdata),
    .periphClkEn(periphClkEn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .perOut(perOut), .perOe(perOe),
    .perIn(perIn)
  );

  ilc_pad_model #(.N(N)) u_ilc_pad_model (
    .sys_clk(sys_clk), .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .padIn(padIn), .perOut(perOut), .perOe(perOe)
  );

  // ========================================================================
  // Clock and bus tasks
  // ========================================================================
  // Free-running 250 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The extra nanosecond lets pads settle before a check.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1;
    chk(busRdata & m, exp);
  endtask : rd

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // ========================================================================
  // Scenarios
  // ========================================================================
  task automatic t_reset();
    rd(`ILC_OFF_OWN_STATE, ALL, ALL);
    rd(`ILC_OFF_DRIVE_STATE, ALL, 32'h0);
    rd(`ILC_OFF_OD_STATE, ALL, 32'h0);
    rd(`ILC_OFF_MASK_STATE, ALL, 32'h0);
    rd(`ILC_OFF_FSEL_LOW, ALL, 32'h0);
    rd(`ILC_OFF_FSEL_HIGH, ALL, 32'h0);
    rd(`ILC_OFF_PD_STATE, ALL, ALL);
    rd(`ILC_OFF_DRIVE_ON_WR, ALL, 32'h0);
    rd(8'hfc, ALL, 32'h0);
  endtask : t_reset

  // Line 8 walks through both refusals of the resistor interlock.
  task automatic t_pull();
    wr(`ILC_OFF_PD_ON_WR, 32'h100);
    rd(`ILC_OFF_PD_STATE, ALL, ALL);
    wr(`ILC_OFF_PU_OFF_WR, 32'h100);
    rd(`ILC_OFF_PU_STATE, ALL, 32'h100);
    wr(`ILC_OFF_PD_ON_WR, 32'h100);
    rd(`ILC_OFF_PD_STATE, ALL, 32'hffff_feff);
    wr(`ILC_OFF_PU_ON_WR, 32'h100);
    rd(`ILC_OFF_PU_STATE, ALL, 32'h100);
    chk(pullDownEn, 32'h100);
    wr(`ILC_OFF_PD_OFF_WR, 32'h100);
  endtask : t_pull

  // Lines 0 to 3: drive, masked direct write, open drain, frozen pin level.
  task automatic t_output();
    wr(`ILC_OFF_DRIVE_ON_WR, 32'h1f);
    wr(`ILC_OFF_DRIVE_OFF_WR, 32'h10);
    rd(`ILC_OFF_DRIVE_STATE, ALL, 32'hf);
    wr(`ILC_OFF_LEVEL_SET_WR, 32'h5);
    chk(padOut & 32'hf, 32'h5);
    wr(`ILC_OFF_DRIVEN_LEVEL, 32'ha);
    rd(`ILC_OFF_DRIVEN_LEVEL, ALL, 32'h5);
    wr(`ILC_OFF_MASK_ON_WR, 32'h7);
    wr(`ILC_OFF_MASK_OFF_WR, 32'h4);
    wr(`ILC_OFF_DRIVEN_LEVEL, 32'ha);
    rd(`ILC_OFF_DRIVEN_LEVEL, ALL, 32'h6);
    wr(`ILC_OFF_LEVEL_CLR_WR, 32'h4);
    wr(`ILC_OFF_OD_ON_WR, 32'h7);
    wr(`ILC_OFF_OD_OFF_WR, 32'h4);
    rd(`ILC_OFF_OD_STATE, ALL, 32'h3);
    chk(padOe & 32'hf, 32'hd);
    chk(padOut & 32'hf, 32'h0);
    rd(`ILC_OFF_PIN_LEVEL, 32'hf, 32'h2);
    @(posedge sys_clk);
    periphClkEn <= 1'b0;
    wr(`ILC_OFF_LEVEL_SET_WR, 32'h1);
    rd(`ILC_OFF_DRIVEN_LEVEL, ALL, 32'h3);
    rd(`ILC_OFF_PIN_LEVEL, 32'hf, 32'h2);
    @(posedge sys_clk);
    periphClkEn <= 1'b1;
    rd(`ILC_OFF_PIN_LEVEL, 32'hf, 32'h3);
  endtask : t_output

  // Lines 4 to 7 take functions A to D; line 9 has no peripheral at all.
  task automatic t_mux();
    wr(`ILC_OFF_OWN_PERI_WR, 32'h2f0);
    rd(`ILC_OFF_OWN_STATE, ALL, 32'hffff_ff0f);
    wr(`ILC_OFF_FSEL_LOW, 32'ha0);
    wr(`ILC_OFF_FSEL_HIGH, 32'hc0);
    rd(`ILC_OFF_FSEL_HIGH, ALL, 32'hc0);
    chk(padOut & 32'hf0, 32'hf0);
    chk(padOe & 32'hf0, 32'h70);
    wr(`ILC_OFF_LEVEL_SET_WR, 32'h10);
    wr(`ILC_OFF_DRIVE_ON_WR, 32'h10);
    rd(`ILC_OFF_DRIVE_STATE, ALL, 32'h1f);
    chk(padOe & 32'hf0, 32'h70);
    wr(`ILC_OFF_OWN_CTRL_WR, 32'hf0);
    chk(padOe & 32'hf0, 32'h10);
    chk(padOut & 32'hf0, 32'h10);
    chk(perIn, padIn);
  endtask : t_mux

  // ========================================================================
  // Main sequence and hang guard
  // ========================================================================
  initial begin
    failures = 0;
    n_checks = 0;
    nrst = 1'b0;
    busReq = '0;
    periphClkEn = 1'b1;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_pull();
    t_output();
    t_mux();
    complete_run();
  end

  // Ends a run that hangs.
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule : tb

bind ilc_io_line_controller ilc_io_line_controller_chk #(.NUM_LINES(NUM_LINES)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .busReq(busReq), .busRdata(busRdata),
  .periphClkEn(periphClkEn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
  .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .perOut(perOut), .perOe(perOe),
  .perIn(perIn)
);
